// File: design/hpgm_pkg.sv
package hpgm_pkg;

	// pin group sizes and positions
	localparam int UPPER_FIRST   = 9;
	localparam int UPPER_LAST    = 15;
	localparam int UPPER_COUNT   = UPPER_LAST - UPPER_FIRST + 1;
	localparam int SHARED_COUNT  = 7;
	localparam int PCI_ONLY_CNT  = 5;
	localparam int CLK_PIN_COUNT = 2;
	localparam int CLK_PIN_GP1   = 0;
	localparam int CLK_PIN_GP2   = 1;

	// clock pin divide ratios from the core clock
	localparam int DIV_QUARTER = 4;
	localparam int DIV_SIXTH   = 6;

	// gpio enable/direction values
	localparam logic GPIO_ENABLED = 1'h1;
	localparam logic DIR_OUTPUT   = 1'h1;
	localparam logic CFG_RESET    = 1'h0;

	// one output/enable pair per pin group
	typedef struct packed {
		logic [SHARED_COUNT-1:0] o;
		logic [SHARED_COUNT-1:0] oe;
	} hpgm_pad7_type;

	typedef struct packed {
		logic [PCI_ONLY_CNT-1:0] o;
		logic [PCI_ONLY_CNT-1:0] oe;
	} hpgm_pad5_type;

	typedef struct packed {
		logic [CLK_PIN_COUNT-1:0] o;
		logic [CLK_PIN_COUNT-1:0] oe;
	} hpgm_pad2_type;

	// software gpio configuration for the clock pins and upper pins
	typedef struct packed {
		logic [CLK_PIN_COUNT-1:0] low_enable;
		logic [CLK_PIN_COUNT-1:0] low_direction;
		logic [UPPER_COUNT-1:0]   up_enable;
		logic [UPPER_COUNT-1:0]   up_direction;
	} hpgm_cfg_type;

endpackage

// File: design/hpgm_clk_div.sv
`timescale 1ns/1ps
module hpgm_clk_div #(
	parameter int DIV = 4
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	output logic      clk_out
);
	import hpgm_pkg::*;

	localparam logic [3:0] HALF_LAST = 4'(DIV / 2 - 1);

	typedef struct packed {
		logic [3:0] cnt;
		logic       clk;
	} hpgm_div_state_type;

	hpgm_div_state_type st_q;
	hpgm_div_state_type st_d;

	// even divide: toggle every DIV/2 core cycles, 50% duty
	always_comb begin
		st_d = st_q;
		if (st_q.cnt == HALF_LAST) begin
			st_d.cnt = 4'h0;
			st_d.clk = ~st_q.clk;
		end else begin
			st_d.cnt = st_q.cnt + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign clk_out = st_q.clk;

endmodule

// File: design/hpgm_pin_mux.sv
// Behaviour
// RQ1 - first clock pin outputs core/4 unless its gpio enable bit is set
// RQ2 - second clock pin outputs core/6 unless its gpio enable bit is set
// RQ3 - clock/gpio choice follows software enable bits, changeable at any time
// RQ4 - pin is gpio only while its enable bit is 1, else other function
// RQ5 - enabled gpio: direction 0 is input, 1 drives gpio output data
// RQ6 - gpio pins 9 to 15 usable only while pci strap captured 0
// RQ7 - strap low at reset: shared pins carry host port, pci disabled
// RQ8 - board holds strap steady during reset and keeps it valid after
// RQ9 - pci disabled: standalone pci pins stay undriven
// RQ10 - strap 1: shared and upper pins take pci, host port and gpio off
// RQ11 - strap captured at reset and used unchanged afterwards
// RQ12 - gpio enable and direction bits reset to 0
`timescale 1ns/1ps
module hpgm_pin_mux (
	input  wire logic                            ref_clk,
	input  wire logic                            reset,
	input  wire logic                            pci_select_strap,
	input  wire hpgm_pkg::hpgm_cfg_type          gpio_cfg,
	input  wire logic [hpgm_pkg::CLK_PIN_COUNT-1:0] gpio_low_out,
	input  wire logic [hpgm_pkg::UPPER_COUNT-1:0]   gpio_up_out,
	input  wire hpgm_pkg::hpgm_pad7_type         host_drive,
	input  wire hpgm_pkg::hpgm_pad7_type         pci_shared_drive,
	input  wire hpgm_pkg::hpgm_pad7_type         pci_upper_drive,
	input  wire hpgm_pkg::hpgm_pad5_type         pci_only_drive,
	input  wire logic [hpgm_pkg::CLK_PIN_COUNT-1:0] clk_pin_in,
	input  wire logic [hpgm_pkg::UPPER_COUNT-1:0]   upper_pin_in,
	input  wire logic [hpgm_pkg::SHARED_COUNT-1:0]  shared_pin_in,
	output hpgm_pkg::hpgm_pad2_type              clk_pin,
	output hpgm_pkg::hpgm_pad7_type              upper_pin,
	output hpgm_pkg::hpgm_pad7_type              shared_pin,
	output hpgm_pkg::hpgm_pad5_type              pci_only_pin,
	output logic [hpgm_pkg::CLK_PIN_COUNT-1:0]   gpio_low_in,
	output logic [hpgm_pkg::UPPER_COUNT-1:0]     gpio_up_in,
	output logic [hpgm_pkg::SHARED_COUNT-1:0]    host_rx,
	output logic [hpgm_pkg::SHARED_COUNT-1:0]    pci_shared_rx,
	output logic [hpgm_pkg::UPPER_COUNT-1:0]     pci_upper_rx,
	output logic                                 pci_enabled,
	output logic                                 host_port_enabled
);
	import hpgm_pkg::*;

	typedef struct packed {
		logic                     pci_en;
		logic                     host_en;
		logic                     run;
		hpgm_cfg_type             cfg;
		hpgm_pad2_type            clk_pin;
		hpgm_pad7_type            upper_pin;
		hpgm_pad7_type            shared_pin;
		hpgm_pad5_type            pci_only_pin;
		logic [CLK_PIN_COUNT-1:0] gpio_low_in;
		logic [UPPER_COUNT-1:0]   gpio_up_in;
		logic [SHARED_COUNT-1:0]  host_rx;
		logic [SHARED_COUNT-1:0]  pci_shared_rx;
		logic [UPPER_COUNT-1:0]   pci_upper_rx;
	} hpgm_state_type;

	hpgm_state_type st_q;
	hpgm_state_type st_d;
	logic           quarter_rate_clock_out;
	logic           sixth_rate_clock_out;
	logic [CLK_PIN_COUNT-1:0] div_clk;

	// free running dividers, kept even while the pin is gpio
	hpgm_clk_div #(.DIV(DIV_QUARTER)) u_div_quarter (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clk_out (quarter_rate_clock_out)
	);

	hpgm_clk_div #(.DIV(DIV_SIXTH)) u_div_sixth (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clk_out (sixth_rate_clock_out)
	);

	assign div_clk[CLK_PIN_GP1] = quarter_rate_clock_out;
	assign div_clk[CLK_PIN_GP2] = sixth_rate_clock_out;

	// pad steering; strap is sampled only while reset is held
	always_comb begin
		st_d = st_q;
		if (reset) begin
			st_d = '0;
			st_d.pci_en = pci_select_strap;                    // RQ11
			st_d.host_en = ~pci_select_strap;                  // RQ7
			st_d.cfg = {$bits(hpgm_cfg_type){CFG_RESET}};       // RQ12
		end else begin
			st_d.run = 1'h1;                                    // first edge out of reset
			st_d.cfg = gpio_cfg;                                // RQ3
			// clock pins: clock by default, gpio when enabled
			for (int i = 0; i < CLK_PIN_COUNT; i++) begin
				if (st_q.cfg.low_enable[i] == GPIO_ENABLED) begin // RQ4
					st_d.clk_pin.o[i] = gpio_low_out[i];
					st_d.clk_pin.oe[i] =
						(st_q.cfg.low_direction[i] == DIR_OUTPUT); // RQ5
					st_d.gpio_low_in[i] =
						~st_d.clk_pin.oe[i] & clk_pin_in[i];
				end else begin
					st_d.clk_pin.o[i] = div_clk[i];              // RQ1 RQ2
					st_d.clk_pin.oe[i] = 1'h1;
					st_d.gpio_low_in[i] = 1'h0;
				end
			end
			// upper pins: pci wins over any gpio setting
			for (int i = 0; i < UPPER_COUNT; i++) begin
				if (st_q.pci_en) begin
					st_d.upper_pin.o[i] = pci_upper_drive.o[i];  // RQ10
					st_d.upper_pin.oe[i] = pci_upper_drive.oe[i];
					st_d.pci_upper_rx[i] = upper_pin_in[i];
					st_d.gpio_up_in[i] = 1'h0;
				end else begin
					st_d.pci_upper_rx[i] = 1'h0;
					st_d.upper_pin.o[i] = gpio_up_out[i];        // RQ6
					st_d.upper_pin.oe[i] =
						(st_q.cfg.up_enable[i] == GPIO_ENABLED) &&
						(st_q.cfg.up_direction[i] == DIR_OUTPUT); // RQ5
					st_d.gpio_up_in[i] =
						(st_q.cfg.up_enable[i] == GPIO_ENABLED) &&
						!st_d.upper_pin.oe[i] && upper_pin_in[i];
				end
			end
			// shared host/pci lanes and standalone pci pins
			if (st_q.pci_en) begin
				st_d.shared_pin = pci_shared_drive;              // RQ10
				st_d.pci_shared_rx = shared_pin_in;
				st_d.host_rx = '0;
				st_d.pci_only_pin = pci_only_drive;
			end else begin
				st_d.shared_pin = host_drive;                    // RQ7
				st_d.host_rx = shared_pin_in;
				st_d.pci_shared_rx = '0;
				st_d.pci_only_pin = '0;                          // RQ9
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		st_q <= st_d;
	end

	// every output straight from the state register
	assign clk_pin           = st_q.clk_pin;
	assign upper_pin         = st_q.upper_pin;
	assign shared_pin        = st_q.shared_pin;
	assign pci_only_pin      = st_q.pci_only_pin;
	assign gpio_low_in       = st_q.gpio_low_in;
	assign gpio_up_in        = st_q.gpio_up_in;
	assign host_rx           = st_q.host_rx;
	assign pci_shared_rx     = st_q.pci_shared_rx;
	assign pci_upper_rx      = st_q.pci_upper_rx;
	assign pci_enabled       = st_q.pci_en;
	assign host_port_enabled = st_q.host_en;

	// checks on the steering
	default clocking cb @(posedge ref_clk); endclocking
	// run is still low at the release edge, whose update came from reset
	default disable iff (reset || !st_q.run);

	property p_quarter_period;
		$rose(quarter_rate_clock_out) |-> ##2 $fell(quarter_rate_clock_out);
	endproperty
	a_quarter_period: assert property (p_quarter_period) // RQ1
		else $error("quarter clock high phase not two cycles");

	property p_sixth_period;
		$rose(sixth_rate_clock_out) |=> $stable(sixth_rate_clock_out)[*2]
			##1 $fell(sixth_rate_clock_out);
	endproperty
	a_sixth_period: assert property (p_sixth_period) // RQ2
		else $error("sixth clock high phase not three cycles");

	property p_clk_default;
		!st_q.cfg.low_enable[CLK_PIN_GP1] |=>
			clk_pin.oe[CLK_PIN_GP1] &&
			clk_pin.o[CLK_PIN_GP1] == $past(quarter_rate_clock_out);
	endproperty
	a_clk_default: assert property (p_clk_default) // RQ1
		else $error("clock pin one not carrying quarter clock");

	property p_sw_switch;
		gpio_cfg.low_enable[CLK_PIN_GP2] && gpio_cfg.low_direction[CLK_PIN_GP2]
			|=> ##1 clk_pin.oe[CLK_PIN_GP2] &&
			clk_pin.o[CLK_PIN_GP2] == $past(gpio_low_out[CLK_PIN_GP2]);
	endproperty
	a_sw_switch: assert property (p_sw_switch) // RQ3
		else $error("clock pin two did not follow software enable");

	property p_gpio_input;
		st_q.cfg.low_enable[CLK_PIN_GP1] &&
			!st_q.cfg.low_direction[CLK_PIN_GP1]
			|=> !clk_pin.oe[CLK_PIN_GP1];
	endproperty
	a_gpio_input: assert property (p_gpio_input) // RQ5
		else $error("gpio input pin is driven");

	property p_upper_gated;
		!st_q.pci_en && !st_q.cfg.up_enable[0] |=> !upper_pin.oe[0];
	endproperty
	a_upper_gated: assert property (p_upper_gated) // RQ4
		else $error("disabled upper gpio pin is driven");

	property p_upper_pci;
		st_q.pci_en |=> upper_pin.oe == $past(pci_upper_drive.oe) &&
			gpio_up_in == '0;
	endproperty
	a_upper_pci: assert property (p_upper_pci) // RQ6
		else $error("upper pins not owned by pci");

	property p_host_mode;
		!st_q.pci_en |=> shared_pin == $past(host_drive) &&
			pci_only_pin.oe == '0;
	endproperty
	a_host_mode: assert property (p_host_mode) // RQ7
		else $error("host mode pins wrong");

	property p_pci_mode;
		st_q.pci_en |=> shared_pin == $past(pci_shared_drive) &&
			host_rx == '0;
	endproperty
	a_pci_mode: assert property (p_pci_mode) // RQ10
		else $error("pci mode pins wrong");

	property p_strap_held;
		##1 $stable(pci_enabled);
	endproperty
	a_strap_held: assert property (p_strap_held) // RQ11
		else $error("captured strap changed after reset");

	property p_cfg_reset;
		@(posedge ref_clk) $fell(reset) |-> st_q.cfg == '0 &&
			clk_pin.oe == '0;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) // RQ12
		else $error("gpio configuration not cleared by reset");

	c_pci_mode:  cover property (st_q.pci_en ##1 shared_pin.oe != '0);
	c_host_mode: cover property (!st_q.pci_en ##1 shared_pin.oe != '0);
	c_gp1_out:   cover property (st_q.cfg.low_enable[CLK_PIN_GP1] &&
		st_q.cfg.low_direction[CLK_PIN_GP1]);
	c_up_in:     cover property (gpio_up_in != '0);

endmodule

// File: verification/hpgm_far_side.sv
`timescale 1ns/1ps
module hpgm_far_side (
	input  wire logic                    ref_clk,
	input  wire logic                    strap_sel,
	input  wire logic                    strap_bad,
	input  wire hpgm_pkg::hpgm_pad2_type clk_pin,
	input  wire hpgm_pkg::hpgm_pad7_type upper_pin,
	input  wire hpgm_pkg::hpgm_pad7_type shared_pin,
	output logic                         strap,
	output logic [1:0]                   clk_pin_in,
	output logic [6:0]                   upper_pin_in,
	output logic [6:0]                   shared_pin_in
);
	import hpgm_pkg::*;

	logic [6:0] pat_q = 7'h55;

	// undriven pads wander every cycle so a stale level never looks valid
	always @(posedge ref_clk) begin
		pat_q <= ~{pat_q[5:0], pat_q[6]};
	end

	// strap stays put unless a scenario asks it to misbehave
	assign strap = strap_bad ? pat_q[0] : strap_sel;
	// pad level: the driver where enabled, else the far side
	assign clk_pin_in    = (clk_pin.oe & clk_pin.o) | (~clk_pin.oe & pat_q[1:0]);
	assign upper_pin_in  = (upper_pin.oe & upper_pin.o) | (~upper_pin.oe & pat_q);
	assign shared_pin_in = (shared_pin.oe & shared_pin.o) |
		(~shared_pin.oe & ~pat_q);
endmodule

// File: verification/tb_host_pci_gpio_pin_mux.sv
`timescale 1ns/1ps
module tb_host_pci_gpio_pin_mux;
	import hpgm_pkg::*;

	logic ref_clk, reset, strap, strap_sel, strap_bad, pe, started;
	hpgm_cfg_type gpio_cfg, mc;
	logic [1:0] gpio_low_out, clk_pin_in, gpio_low_in, dv, le, ld;
	logic [6:0] gpio_up_out, upper_pin_in, shared_pin_in, ue, ud;
	hpgm_pad7_type host_drive, pci_shared_drive, pci_upper_drive;
	hpgm_pad7_type upper_pin, shared_pin;
	hpgm_pad5_type pci_only_drive, pci_only_pin;
	hpgm_pad2_type clk_pin;
	logic [6:0] gpio_up_in, host_rx, pci_shared_rx, pci_upper_rx;
	logic pci_enabled, host_port_enabled;
	logic [31:0] ea, eb, ec, seed;
	int n, fails, checked;

	hpgm_pin_mux dut_u (.ref_clk(ref_clk), .reset(reset),
		.pci_select_strap(strap), .gpio_cfg(gpio_cfg),
		.gpio_low_out(gpio_low_out), .gpio_up_out(gpio_up_out),
		.host_drive(host_drive), .pci_shared_drive(pci_shared_drive),
		.pci_upper_drive(pci_upper_drive), .pci_only_drive(pci_only_drive),
		.clk_pin_in(clk_pin_in), .upper_pin_in(upper_pin_in),
		.shared_pin_in(shared_pin_in), .clk_pin(clk_pin),
		.upper_pin(upper_pin), .shared_pin(shared_pin),
		.pci_only_pin(pci_only_pin), .gpio_low_in(gpio_low_in),
		.gpio_up_in(gpio_up_in), .host_rx(host_rx),
		.pci_shared_rx(pci_shared_rx), .pci_upper_rx(pci_upper_rx),
		.pci_enabled(pci_enabled), .host_port_enabled(host_port_enabled));

	hpgm_far_side far_u (.ref_clk(ref_clk), .strap_sel(strap_sel),
		.strap_bad(strap_bad), .clk_pin(clk_pin), .upper_pin(upper_pin),
		.shared_pin(shared_pin), .strap(strap), .clk_pin_in(clk_pin_in),
		.upper_pin_in(upper_pin_in), .shared_pin_in(shared_pin_in));

	initial begin
		ref_clk = 1'h0;
		forever #2 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// reference model: config lags one edge more than the pad data
	always @(posedge ref_clk) begin
		if (reset) begin
			pe = strap;
			n = 0;
			mc = '0;
			ea = '0;
			eb = '0;
			ec = {30'h0, strap, ~strap};
			started = 1'h1;
		end else begin
			n = n + 1;
			dv = {1'(((n - 1) / (DIV_SIXTH / 2)) % 2),
				1'(((n - 1) / (DIV_QUARTER / 2)) % 2)};
			le = mc.low_enable;
			ld = mc.low_direction;
			ue = mc.up_enable & {7{~pe}};
			ud = mc.up_direction;
			ea[31:14] = {(le & gpio_low_out) | (~le & dv), ~le | ld,
				pe ? pci_upper_drive.o : gpio_up_out,
				pe ? pci_upper_drive.oe : ue & ud};
			ea[13:0] = pe ? pci_shared_drive : host_drive;
			eb = {6'h0, pe ? pci_only_drive : 10'h000,
				le & ~ld & clk_pin_in, ue & ~ud & upper_pin_in,
				pe ? 7'h00 : shared_pin_in};
			ec = {16'h0, pe ? shared_pin_in : 7'h00,
				pe ? upper_pin_in : 7'h00, pe, ~pe};
			mc = gpio_cfg;
		end
	end

	// outputs are settled half a cycle after the edge
	always @(negedge ref_clk) begin
		if (started) begin
			check({clk_pin, upper_pin, shared_pin}, ea);
			check({pci_only_pin, gpio_low_in, gpio_up_in, host_rx}, eb);
			check({pci_shared_rx, pci_upper_rx, pci_enabled,
				host_port_enabled}, ec);
		end
	end

	// random traffic; config held a few cycles so gpio modes settle
	task automatic traffic(input int k);
		logic [31:0] r;
		for (int i = 0; i < k; i++) begin
			@(posedge ref_clk);
			r = rnd();
			if (i % 4 == 0) begin
				gpio_cfg <= r[17:0];
			end
			gpio_low_out <= r[19:18];
			gpio_up_out <= r[26:20];
			r = rnd();
			host_drive <= r[13:0];
			pci_shared_drive <= r[27:14];
			r = rnd();
			pci_upper_drive <= r[13:0];
			pci_only_drive <= r[23:14];
		end
	endtask

	task automatic do_reset(input logic sel);
		@(posedge ref_clk);
		reset <= 1'h1;
		strap_sel <= sel;
		strap_bad <= 1'h0;
		repeat (5) @(posedge ref_clk);
		reset <= 1'h0;
	endtask

	initial begin
		seed = 32'h00012229;
		fails = 0;
		checked = 0;
		reset = 1'h1;
		strap_sel = 1'h0;
		strap_bad = 1'h0;
		gpio_cfg = '0;
		gpio_low_out = '0;
		gpio_up_out = '0;
		host_drive = '0;
		pci_shared_drive = '0;
		pci_upper_drive = '0;
		pci_only_drive = '0;
		repeat (5) @(posedge ref_clk);
		reset <= 1'h0;
		traffic(400);
		do_reset(1'h1);
		traffic(300);
		strap_bad <= 1'h1;
		traffic(200);
		do_reset(1'h0);
		traffic(100);
		final_report();
	end

	// watchdog well past the planned run
	initial begin
		repeat (3000) @(posedge ref_clk);
		fails++;
		final_report();
	end
endmodule
